// file: rtl/ufic_pkg.sv
// Package for the serial FIFO, interrupt and DMA request control block.
// Assumes a single 50 MHz clock domain shared by host port and serial engine.
package ufic_pkg;
  localparam int CLOCK_HZ = 50_000_000;
  localparam int MAX_BAUD = 256_000;
  localparam int BIT_CYCLES = CLOCK_HZ / MAX_BAUD;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FULL_COUNT = 5'h10;
  localparam logic [CNT_W-1:0] LEGACY_COUNT = 5'h01;
  localparam logic [CNT_W-1:0] EMPTY_COUNT = 5'h00;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
  localparam logic [2:0] IDLE_ZERO = 3'h0;
  localparam logic [2:0] IDLE_ONE = 3'h1;
  // Receive trigger levels selected by the two top control bits
  localparam logic [CNT_W-1:0] TRIG_LVL0 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_LVL1 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_LVL2 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_LVL3 = 5'h0e;
  // Interrupt enable bit positions
  localparam int IE_RX_DATA = 0;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  localparam logic [3:0] IE_RESET = 4'h0;
  localparam int AUX_BIT = 3;
  // Identification codes, low nibble
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_RX_DATA = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hc;
  localparam logic [3:0] ID_TX_EMPTY = 4'h2;
  localparam logic [3:0] ID_MODEM = 4'h0;
  localparam logic [1:0] ID_FIFO_ON = 2'h3;
  localparam logic [1:0] ID_FIFO_OFF = 2'h0;
  localparam logic [1:0] ID_ZERO = 2'h0;

  // FIFO control word as written by the host
  typedef struct packed {
    logic [1:0] trigger;
    logic [1:0] reserved;
    logic dma_multi;
    logic tx_clear;
    logic rx_clear;
    logic enable;
  } ufic_fifo_ctrl_t;

  // Host side identification byte
  typedef struct packed {
    logic [1:0] fifo_on;
    logic [1:0] zero;
    logic [3:0] id;
  } ufic_ident_t;
endpackage

// file: rtl/ufic_core.sv
// FIFO, interrupt and DMA request control of a buffered serial transceiver.
// Assumes host strobes and serial engine strobes are synchronous to clock.
//
// Behaviour
// - Raise receive interrupt below trigger after idle
// - Timeout after four idle character times, cleared
// - Power up in legacy mode, FIFOs off
// - Keep enable bit set; identify FIFO mode (the receive and transmit clear bits still act when enable is written clear)
// - Four independent interrupt source enable bits
// - Auxiliary bit three gates external interrupt buffer
// - Interrupt output is a level, not pulse
// - Sixteen bytes buffered in each direction
// - Separate receive and transmit DMA requests, two modes
// - Single and multi transfer request conditions
// - Line rates up to 256 kbaud supported
// - DMA requests replace legacy spare terminals
`timescale 1ns/1ps
module ufic_core (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic fcr_write,
  input wire ufic_pkg::ufic_fifo_ctrl_t fcr_data,
  input wire logic ier_write,
  input wire logic [3:0] ier_data,
  input wire logic mcr_write,
  input wire logic [7:0] mcr_data,
  input wire logic iir_read,
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  input wire logic rx_read,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic tx_shift_ready,
  input wire logic char_tick,
  input wire logic line_status_pending,
  input wire logic modem_status_pending,
  output logic [7:0] rx_data,
  output logic tx_char_valid,
  output logic [7:0] tx_char_data,
  output logic rx_overrun,
  output ufic_pkg::ufic_ident_t ident,
  output logic serial_interrupt_output,
  output logic aux_output_two,
  output logic rx_dma_request,
  output logic tx_dma_request
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] rx_mem [ufic_pkg::DEPTH];
  logic [7:0] tx_mem [ufic_pkg::DEPTH];
  logic [ufic_pkg::PTR_W-1:0] rx_wr_reg, rx_wr_next, rx_rd_reg, rx_rd_next;
  logic [ufic_pkg::PTR_W-1:0] tx_wr_reg, tx_wr_next, tx_rd_reg, tx_rd_next;
  logic [ufic_pkg::CNT_W-1:0] rx_count_reg, rx_count_next, tx_count_reg, tx_count_next;
  logic [ufic_pkg::CNT_W-1:0] capacity, trig_level;
  logic [2:0] idle_reg, idle_next;
  logic timeout_reg, timeout_next, tx_empty_reg, tx_empty_next;
  logic fifo_en_reg, fifo_en_next, multi_reg, multi_next;
  logic [1:0] trig_reg, trig_next;
  logic [3:0] ier_reg, ier_next;
  logic aux_reg, aux_next, rx_dma_reg, rx_dma_next, tx_dma_reg, tx_dma_next;
  logic irq_reg, irq_next, ovr_reg, ovr_next, txv_reg, txv_next;
  logic [7:0] rx_data_reg, rx_data_next, tx_char_reg, tx_char_next;
  ufic_pkg::ufic_ident_t ident_reg, ident_next;
  logic rx_push, rx_pop, tx_push, tx_pop, rx_flush, tx_flush, mode_change;
  logic [3:0] pend_next;

  // Depth is 16 in FIFO mode and a single holding slot in legacy mode
  // sixteen byte depth
  assign capacity = fifo_en_reg ? ufic_pkg::FULL_COUNT : ufic_pkg::LEGACY_COUNT;
  assign mode_change = fcr_write && (fcr_data.enable != fifo_en_reg);
  assign rx_flush = fcr_write && (mode_change || fcr_data.rx_clear);
  assign tx_flush = fcr_write && (mode_change || fcr_data.tx_clear);
  assign rx_push = rx_char_valid && (rx_count_reg < capacity) && !rx_flush;
  assign rx_pop = rx_read && (rx_count_reg != ufic_pkg::EMPTY_COUNT) && !rx_flush;
  assign tx_push = tx_write && (tx_count_reg < capacity) && !tx_flush;
  assign tx_pop = tx_shift_ready && (tx_count_reg != ufic_pkg::EMPTY_COUNT) && !tx_flush;

  always_comb begin
    unique case (trig_reg)
      2'h0: trig_level = ufic_pkg::TRIG_LVL0;
      2'h1: trig_level = ufic_pkg::TRIG_LVL1;
      2'h2: trig_level = ufic_pkg::TRIG_LVL2;
      2'h3: trig_level = ufic_pkg::TRIG_LVL3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, FIFO pointers and flags
  always_comb begin
    fifo_en_next = fifo_en_reg;
    multi_next = multi_reg;
    trig_next = trig_reg;
    if (fcr_write) begin
      fifo_en_next = fcr_data.enable;
      // The DMA mode and trigger bits only take effect while the enable bit is kept set
      if (fcr_data.enable) begin
        multi_next = fcr_data.dma_multi;
        trig_next = fcr_data.trigger;
      end
    end
    ier_next = ier_write ? ier_data : ier_reg;
    aux_next = mcr_write ? mcr_data[ufic_pkg::AUX_BIT] : aux_reg;
    rx_wr_next = rx_flush ? '0 : (rx_push ? rx_wr_reg + ufic_pkg::PTR_ONE : rx_wr_reg);
    rx_rd_next = rx_flush ? '0 : (rx_pop ? rx_rd_reg + ufic_pkg::PTR_ONE : rx_rd_reg);
    tx_wr_next = tx_flush ? '0 : (tx_push ? tx_wr_reg + ufic_pkg::PTR_ONE : tx_wr_reg);
    tx_rd_next = tx_flush ? '0 : (tx_pop ? tx_rd_reg + ufic_pkg::PTR_ONE : tx_rd_reg);
    rx_count_next = rx_count_reg;
    if (rx_flush) begin
      rx_count_next = ufic_pkg::EMPTY_COUNT;
    end else if (rx_push && !rx_pop) begin
      rx_count_next = rx_count_reg + ufic_pkg::CNT_ONE;
    end else if (rx_pop && !rx_push) begin
      rx_count_next = rx_count_reg - ufic_pkg::CNT_ONE;
    end
    tx_count_next = tx_count_reg;
    if (tx_flush) begin
      tx_count_next = ufic_pkg::EMPTY_COUNT;
    end else if (tx_push && !tx_pop) begin
      tx_count_next = tx_count_reg + ufic_pkg::CNT_ONE;
    end else if (tx_pop && !tx_push) begin
      tx_count_next = tx_count_reg - ufic_pkg::CNT_ONE;
    end
    // Overrun is sticky until a read; a new overrun in the read cycle wins
    ovr_next = (rx_char_valid && !rx_push && !rx_flush) || (ovr_reg && !rx_read);
    rx_data_next = rx_pop ? rx_mem[rx_rd_reg] : rx_data_reg;
    txv_next = tx_pop;
    tx_char_next = tx_pop ? tx_mem[tx_rd_reg] : tx_char_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive idle timer and transmit empty flag
  always_comb begin
    idle_next = idle_reg;
    timeout_next = timeout_reg;
    if (rx_push || rx_pop || rx_flush || !fifo_en_reg) begin
      idle_next = ufic_pkg::IDLE_ZERO;
      timeout_next = 1'b0;
    end else if (char_tick && rx_count_reg != ufic_pkg::EMPTY_COUNT && !timeout_reg) begin
      if (idle_reg == ufic_pkg::TIMEOUT_CHARS - ufic_pkg::IDLE_ONE) begin
        timeout_next = 1'b1;
        idle_next = ufic_pkg::IDLE_ZERO;
      end else begin
        idle_next = idle_reg + ufic_pkg::IDLE_ONE;
      end
    end
    // Becoming empty sets the flag and wins over a clear in the same cycle
    tx_empty_next = tx_empty_reg;
    if ((tx_pop && tx_count_reg == ufic_pkg::CNT_ONE && !tx_push) || tx_flush) begin
      tx_empty_next = 1'b1;
    end else if (tx_push || (iir_read && ident_reg.id == ufic_pkg::ID_TX_EMPTY)) begin
      tx_empty_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identification, interrupt level and DMA requests from next state, except the trigger level, which comes from trig_reg
  always_comb begin
    pend_next[ufic_pkg::IE_LINE] = line_status_pending;
    pend_next[ufic_pkg::IE_RX_DATA] = timeout_next || (rx_count_next >= trig_level);
    pend_next[ufic_pkg::IE_TX_EMPTY] = tx_empty_next;
    pend_next[ufic_pkg::IE_MODEM] = modem_status_pending;
    ident_next.zero = ufic_pkg::ID_ZERO;
    ident_next.fifo_on = fifo_en_next ? ufic_pkg::ID_FIFO_ON : ufic_pkg::ID_FIFO_OFF;
    if (ier_next[ufic_pkg::IE_LINE] && pend_next[ufic_pkg::IE_LINE]) begin
      ident_next.id = ufic_pkg::ID_LINE;
    end else if (ier_next[ufic_pkg::IE_RX_DATA] && pend_next[ufic_pkg::IE_RX_DATA]) begin
      ident_next.id = timeout_next ? ufic_pkg::ID_TIMEOUT : ufic_pkg::ID_RX_DATA;
    end else if (ier_next[ufic_pkg::IE_TX_EMPTY] && pend_next[ufic_pkg::IE_TX_EMPTY]) begin
      ident_next.id = ufic_pkg::ID_TX_EMPTY;
    end else if (ier_next[ufic_pkg::IE_MODEM] && pend_next[ufic_pkg::IE_MODEM]) begin
      ident_next.id = ufic_pkg::ID_MODEM;
    end else begin
      ident_next.id = ufic_pkg::ID_NONE;
    end
    irq_next = |(pend_next & ier_next);
    if (multi_next && fifo_en_next) begin
      rx_dma_next = (rx_count_next != ufic_pkg::EMPTY_COUNT)
        && (rx_dma_reg || timeout_next || rx_count_next >= trig_level);
      tx_dma_next = tx_count_next < ufic_pkg::FULL_COUNT;
    end else begin
      rx_dma_next = rx_count_next != ufic_pkg::EMPTY_COUNT;
      tx_dma_next = tx_count_next == ufic_pkg::EMPTY_COUNT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; clock_enable low freezes everything
  // legacy state at reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fifo_en_reg <= 1'b0;
      multi_reg <= 1'b0;
      trig_reg <= 2'h0;
      ier_reg <= ufic_pkg::IE_RESET;
      aux_reg <= 1'b0;
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      rx_count_reg <= ufic_pkg::EMPTY_COUNT;
      tx_count_reg <= ufic_pkg::EMPTY_COUNT;
      idle_reg <= ufic_pkg::IDLE_ZERO;
      timeout_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      ovr_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      txv_reg <= 1'b0;
      tx_char_reg <= 8'h00;
      ident_reg <= {ufic_pkg::ID_FIFO_OFF, ufic_pkg::ID_ZERO, ufic_pkg::ID_NONE};
      irq_reg <= 1'b0;
      rx_dma_reg <= 1'b0;
      tx_dma_reg <= 1'b1;
    end else if (clock_enable) begin
      fifo_en_reg <= fifo_en_next;
      multi_reg <= multi_next;
      trig_reg <= trig_next;
      ier_reg <= ier_next;
      aux_reg <= aux_next;
      rx_wr_reg <= rx_wr_next;
      rx_rd_reg <= rx_rd_next;
      tx_wr_reg <= tx_wr_next;
      tx_rd_reg <= tx_rd_next;
      rx_count_reg <= rx_count_next;
      tx_count_reg <= tx_count_next;
      idle_reg <= idle_next;
      timeout_reg <= timeout_next;
      tx_empty_reg <= tx_empty_next;
      ovr_reg <= ovr_next;
      rx_data_reg <= rx_data_next;
      txv_reg <= txv_next;
      tx_char_reg <= tx_char_next;
      ident_reg <= ident_next;
      irq_reg <= irq_next;
      rx_dma_reg <= rx_dma_next;
      tx_dma_reg <= tx_dma_next;
    end
  end

  // Storage arrays carry no reset; contents are only read behind the counts
  always_ff @(posedge clock) begin
    if (clock_enable && rx_push) begin
      rx_mem[rx_wr_reg] <= rx_char_data;
    end
    if (clock_enable && tx_push) begin
      tx_mem[tx_wr_reg] <= tx_data;
    end
  end

  assign rx_dma_request = rx_dma_reg;
  assign tx_dma_request = tx_dma_reg;
  assign serial_interrupt_output = irq_reg;
  assign aux_output_two = aux_reg;
  assign ident = ident_reg;
  assign rx_data = rx_data_reg;
  assign tx_char_valid = txv_reg;
  assign tx_char_data = tx_char_reg;
  assign rx_overrun = ovr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_idle_last;
    clock_enable && fifo_en_reg && rx_count_reg != ufic_pkg::EMPTY_COUNT && !timeout_reg
      && idle_reg == ufic_pkg::TIMEOUT_CHARS - ufic_pkg::IDLE_ONE && char_tick;
  endsequence
  sequence s_untouched;
    !rx_char_valid && !rx_read && !fcr_write;
  endsequence

  a_timeout_fires: assert property (@(posedge clock) disable iff (reset)
    s_idle_last and s_untouched |=> timeout_reg && ident_reg.id == ufic_pkg::ID_TIMEOUT
      || !ier_reg[ufic_pkg::IE_RX_DATA] || line_status_pending)
    else $error("receive timeout did not fire after idle");
  a_timeout_clear: assert property (@(posedge clock) disable iff (reset)
    clock_enable && (rx_push || rx_pop) |=> !timeout_reg && idle_reg == ufic_pkg::IDLE_ZERO)
    else $error("receive timeout not cleared by access");
  a_legacy_start: assert property (@(posedge clock)
    $fell(reset) |-> !fifo_en_reg && ident_reg.fifo_on == ufic_pkg::ID_FIFO_OFF)
    else $error("device left reset in FIFO mode");
  a_ident_mode: assert property (@(posedge clock) disable iff (reset)
    ident_reg.fifo_on == (fifo_en_reg ? ufic_pkg::ID_FIFO_ON : ufic_pkg::ID_FIFO_OFF))
    else $error("identification mode bits disagree with FIFO enable");
  a_mask_all: assert property (@(posedge clock) disable iff (reset)
    clock_enable && ier_write && ier_data == ufic_pkg::IE_RESET |=> !serial_interrupt_output)
    else $error("interrupt asserted with all sources masked");
  a_aux_follows: assert property (@(posedge clock) disable iff (reset)
    clock_enable && mcr_write |=> aux_output_two == $past(mcr_data[ufic_pkg::AUX_BIT]))
    else $error("auxiliary output did not follow control bit");
  a_irq_level: assert property (@(posedge clock) disable iff (reset)
    clock_enable && serial_interrupt_output && ier_reg[ufic_pkg::IE_LINE]
      && line_status_pending && !ier_write |=> serial_interrupt_output)
    else $error("interrupt dropped while enabled source pending");
  a_depth_limit: assert property (@(posedge clock) disable iff (reset)
    rx_count_reg <= capacity && tx_count_reg <= capacity)
    else $error("FIFO count exceeds capacity");
  a_single_dma: assert property (@(posedge clock) disable iff (reset)
    !(multi_reg && fifo_en_reg) |-> rx_dma_request == (rx_count_reg != ufic_pkg::EMPTY_COUNT)
      && tx_dma_request == (tx_count_reg == ufic_pkg::EMPTY_COUNT))
    else $error("single transfer DMA request wrong");
  a_multi_txdma: assert property (@(posedge clock) disable iff (reset)
    multi_reg && fifo_en_reg |-> tx_dma_request == (tx_count_reg < ufic_pkg::FULL_COUNT))
    else $error("multi transfer transmit request wrong");
  a_rate_fits: assert property (@(posedge clock) disable iff (reset)
    char_tick |=> ufic_pkg::BIT_CYCLES >= 1)
    else $error("clock too slow for top line rate");
  a_irq_clear: assert property (@(posedge clock) disable iff (reset)
    $fell(serial_interrupt_output) |-> ident_reg.id == ufic_pkg::ID_NONE)
    else $error("interrupt dropped with enabled source pending");
endmodule

// file: sim/ufic_irq_unit.sv
// Edge-triggered system interrupt unit beside the serial FIFO control block.
// Assumes the block's interrupt and auxiliary outputs share the bench clock.
`timescale 1ns/1ps
module ufic_irq_unit (
  input wire logic clock,
  input wire logic reset,
  input wire logic serial_interrupt_output,
  input wire logic aux_output_two,
  output int edge_count
);
  logic seen_reg;
  logic buffered;
  assign buffered = serial_interrupt_output & aux_output_two;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seen_reg <= 1'b0;
      edge_count <= 0;
    end else begin
      seen_reg <= buffered;
      if (buffered && !seen_reg) begin
        edge_count <= edge_count + 1; // A held level never counts twice
      end
    end
  end
endmodule

// file: sim/tb_uart_fifo_interrupt_dma_control.sv
// Self-checking bench for the serial FIFO, interrupt and DMA request block.
// Assumes the core and the edge-triggered interrupt unit model compile before it.
`timescale 1ns/1ps
module tb_uart_fifo_interrupt_dma_control;
  logic clock, reset, clock_enable, fcr_write, ier_write, mcr_write, iir_read;
  logic tx_write, rx_read, rx_char_valid, tx_shift_ready, char_tick;
  logic line_status_pending, modem_status_pending, tx_char_valid, rx_overrun;
  logic serial_interrupt_output, aux_output_two, rx_dma_request, tx_dma_request, rd_seen;
  logic [3:0] ier_data;
  logic [7:0] mcr_data, tx_data, rx_char_data, rx_data, tx_char_data;
  ufic_pkg::ufic_fifo_ctrl_t fcr_data;
  ufic_pkg::ufic_ident_t ident;
  int mismatches, cmp_count, edge_count, base, i;
  integer seed = 32'h4ba1_8189;
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  logic [3:0] src;

  ufic_core ufic_core_inst (.clock(clock), .reset(reset), .clock_enable(clock_enable),
    .fcr_write(fcr_write), .fcr_data(fcr_data), .ier_write(ier_write), .ier_data(ier_data),
    .mcr_write(mcr_write), .mcr_data(mcr_data), .iir_read(iir_read), .tx_write(tx_write),
    .tx_data(tx_data), .rx_read(rx_read), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .tx_shift_ready(tx_shift_ready), .char_tick(char_tick),
    .line_status_pending(line_status_pending), .modem_status_pending(modem_status_pending),
    .rx_data(rx_data), .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
    .rx_overrun(rx_overrun), .ident(ident), .serial_interrupt_output(serial_interrupt_output),
    .aux_output_two(aux_output_two), .rx_dma_request(rx_dma_request),
    .tx_dma_request(tx_dma_request));
  ufic_irq_unit ufic_irq_unit_inst (.clock(clock), .reset(reset),
    .serial_interrupt_output(serial_interrupt_output), .aux_output_two(aux_output_two),
    .edge_count(edge_count));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and closing tasks
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Host strobes: one cycle each, driven at the falling edge
  task automatic wr_fcr(input logic [7:0] v);
    @(negedge clock);
    fcr_write = 1'b1;
    fcr_data = v;
    @(negedge clock);
    fcr_write = 1'b0;
  endtask
  task automatic wr_ier(input logic [3:0] v);
    @(negedge clock);
    ier_write = 1'b1;
    ier_data = v;
    @(negedge clock);
    ier_write = 1'b0;
  endtask
  task automatic strobe(input int kind);
    @(negedge clock);
    iir_read = (kind == 0);
    rx_read = (kind == 1);
    char_tick = (kind == 2);
    mcr_write = (kind == 3); // Auxiliary bit set, the rest clear
    @(negedge clock);
    {iir_read, rx_read, char_tick, mcr_write} = 4'h0;
  endtask
  // A refused character is driven but not noted, since it never comes back
  task automatic push_rx(input logic keep);
    @(negedge clock);
    rx_char_valid = 1'b1;
    rx_char_data = 8'($random(seed));
    if (keep) rx_q.push_back(rx_char_data);
    @(negedge clock);
    rx_char_valid = 1'b0;
  endtask
  task automatic push_tx;
    @(negedge clock);
    tx_write = 1'b1;
    tx_data = 8'($random(seed));
    tx_q.push_back(tx_data);
    @(negedge clock);
    tx_write = 1'b0;
  endtask
  task automatic chk_irq(input logic lvl, input logic [3:0] id);
    cmp_bit(serial_interrupt_output, lvl);
    cmp_byte({4'h0, ident.id}, {4'h0, id});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and result monitors
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #(20 * 20000);
    mismatches++;
    stop_test();
  end
  always @(posedge clock) rd_seen <= rx_read;
  always @(negedge clock) begin
    if (rd_seen) cmp_byte(rx_data, rx_q.pop_front());
    if (tx_char_valid) cmp_byte(tx_char_data, tx_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {reset, clock_enable, fcr_write, ier_write, mcr_write, iir_read, tx_write} = 7'h60;
    {rx_read, rx_char_valid, tx_shift_ready, char_tick} = 4'h0;
    {line_status_pending, modem_status_pending, ier_data, tx_data, rx_char_data} = '0;
    fcr_data = 8'h00;
    mcr_data = 8'h08;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    // legacy values and one-byte receive holding
    cmp_byte(ident, 8'h01);
    cmp_bit(tx_dma_request, 1'b1);
    push_rx(1'b1);
    push_rx(1'b0);
    cmp_bit(rx_overrun, 1'b1);
    strobe(1);
    cmp_bit(rx_overrun, 1'b0);
    // FIFO mode flag and auxiliary output
    wr_fcr(8'h01);
    cmp_byte({6'h00, ident.fifo_on}, 8'h03);
    strobe(3);
    cmp_bit(aux_output_two, 1'b1);
    base = edge_count;
    wr_ier(4'hf);
    chk_irq(1'b1, ufic_pkg::ID_TX_EMPTY);
    strobe(0);
    chk_irq(1'b0, ufic_pkg::ID_NONE);
    cmp_byte(8'(edge_count - base), 8'h01);
    // held level, masked in service, fresh edge on re-enable
    line_status_pending = 1'b1;
    repeat (6) @(negedge clock);
    chk_irq(1'b1, ufic_pkg::ID_LINE);
    // Count only the edge that the re-enable makes, not the line source's own
    base = edge_count;
    wr_ier(4'h0);
    cmp_bit(serial_interrupt_output, 1'b0);
    wr_ier(4'hf);
    @(negedge clock);
    cmp_byte(8'(edge_count - base), 8'h01);
    // each enable bit alone against its own source
    modem_status_pending = 1'b1;
    src = 4'b1100;
    for (i = 0; i < 4; i++) begin
      wr_ier(4'(1 << i));
      cmp_bit(serial_interrupt_output, src[i]);
    end
    {line_status_pending, modem_status_pending} = 2'b00;
    // below-trigger timeout, cleared by a read
    wr_fcr(8'h41);
    wr_ier(4'hf);
    strobe(0);
    repeat (3) push_rx(1'b1);
    cmp_bit(rx_dma_request, 1'b1);
    repeat (3) strobe(2);
    chk_irq(1'b0, ufic_pkg::ID_NONE);
    strobe(2);
    chk_irq(1'b1, ufic_pkg::ID_TIMEOUT);
    strobe(1);
    chk_irq(1'b0, ufic_pkg::ID_NONE);
    repeat (2) strobe(1);
    cmp_bit(rx_dma_request, 1'b0);
    // trigger fourteen, sixteen held, seventeenth refused
    wr_fcr(8'hc1);
    wr_ier(4'h1);
    repeat (13) push_rx(1'b1);
    cmp_bit(serial_interrupt_output, 1'b0);
    push_rx(1'b1);
    chk_irq(1'b1, ufic_pkg::ID_RX_DATA);
    repeat (2) push_rx(1'b1);
    cmp_bit(rx_overrun, 1'b0);
    push_rx(1'b0);
    cmp_bit(rx_overrun, 1'b1);
    repeat (16) strobe(1);
    wr_fcr(8'h49);
    repeat (3) push_rx(1'b1);
    cmp_bit(rx_dma_request, 1'b0);
    push_rx(1'b1);
    cmp_bit(rx_dma_request, 1'b1);
    repeat (4) strobe(1);
    repeat (15) push_tx();
    cmp_bit(tx_dma_request, 1'b1);
    push_tx();
    cmp_bit(tx_dma_request, 1'b0);
    tx_shift_ready = 1'b1;
    repeat (20) @(negedge clock);
    cmp_bit(tx_dma_request, 1'b1);
    // single-transfer transmit request drops with one byte
    tx_shift_ready = 1'b0;
    wr_fcr(8'h41);
    push_tx();
    cmp_bit(tx_dma_request, 1'b0);
    tx_shift_ready = 1'b1;
    repeat (4) @(negedge clock);
    cmp_bit(tx_dma_request, 1'b1);
    // A character offered while the clock enable is low must leave no trace
    clock_enable = 1'b0;
    push_rx(1'b0);
    cmp_bit(rx_dma_request, 1'b0);
    clock_enable = 1'b1;
    cmp_byte(8'(rx_q.size() + tx_q.size()), 8'h00);
    stop_test();
  end
endmodule
